/* File: hw/cmd_link_pkg.sv */
/*
 * Constants shared by both ends of the sub-unit command link: word layout,
 * sub-unit addresses, command codes, link timing and controller register map.
 * Assumes a single 100 MHz system clock at both ends.
 */
package cmd_link_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int LINK_BIT_RATE_HZ = 312500;
	localparam int BIT_CYCLES = CLK_HZ / LINK_BIT_RATE_HZ;
	localparam int WORD_W = 32;
	localparam int SUBUNITS = 3;
	localparam int ADDR_LSB = 24;
	localparam int ID_LSB = 16;
	localparam int INDIV_BIT = 31;
	localparam logic [7:0] ADDR_BCAST = 8'hFF;
	localparam logic [7:0] ADDR_DETECTOR = 8'h01;
	localparam logic [7:0] ADDR_MECHANISM = 8'h02;
	localparam logic [7:0] ADDR_SUBSYSTEM = 8'h03;
	localparam logic [7:0] CMD_ACK_REQ = 8'h01;
	localparam logic [7:0] CMD_HK_READ = 8'h02;
	localparam int ERR_FRAME = 0;
	localparam int ERR_OVERRUN = 1;
	localparam int RSP_TIMEOUT_BITS = 100;
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_CTRL = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_RSP = 12'h00C;
	localparam logic [11:0] REG_RSP_SRC = 12'h010;
	localparam logic [11:0] REG_IRQ_STAT = 12'h014;
	localparam logic [11:0] REG_IRQ_MASK = 12'h018;
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TIMEOUT = 1;
	localparam int IRQ_RSP_ERR = 2;

	function automatic logic [7:0] addr_of(input logic [WORD_W-1:0] w);
		return w[ADDR_LSB+:8];
	endfunction : addr_of

	function automatic logic [7:0] id_of(input logic [WORD_W-1:0] w);
		return w[ID_LSB+:8];
	endfunction : id_of

	function automatic logic [7:0] subunit_addr(input int idx);
		case (idx)
			0: return ADDR_DETECTOR;
			1: return ADDR_MECHANISM;
			default: return ADDR_SUBSYSTEM;
		endcase
	endfunction : subunit_addr
endpackage : cmd_link_pkg

/* File: hw/cmd_link_if.sv */
/*
 * Three point-to-point command links, one per sub-unit, each made of a
 * command line towards the sub-unit and a response line back.
 * Both lines idle high; the bench joins the two ends through this interface.
 */
interface cmd_link_if;
	import cmd_link_pkg::*;
	logic [SUBUNITS-1:0] cmd_line;
	logic [SUBUNITS-1:0] rsp_line;
	modport master (output cmd_line, input rsp_line);
	modport subunit (input cmd_line, output rsp_line);
endinterface : cmd_link_if

/* File: hw/word_serdes.sv */
/*
 * Serial word transmitter and receiver for one link end.
 * Frame: start bit low, data MSB first, stop bit high; line idles high.
 * Assumes rx_line_i is asynchronous and synchronises it here.
 */
module word_serdes #(
	parameter int BIT_CYCLES = cmd_link_pkg::BIT_CYCLES,
	parameter int WORD_W = cmd_link_pkg::WORD_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic tx_valid_i,
	input wire logic [WORD_W-1:0] tx_word_i,
	output logic tx_busy_o,
	output logic tx_line_o,
	input wire logic rx_line_i,
	output logic rx_valid_o,
	output logic [WORD_W-1:0] rx_word_o,
	output logic rx_err_o
);
	localparam int CW = $clog2(2 * BIT_CYCLES);
	localparam int NW = $clog2(WORD_W + 2);
	logic [WORD_W:0] tx_sh_q;
	logic [CW-1:0] tx_cnt_q;
	logic [NW-1:0] tx_bits_q;
	logic rx_s1_q;
	logic rx_s2_q;
	logic rx_act_q;
	logic [WORD_W-1:0] rx_sh_q;
	logic [CW-1:0] rx_cnt_q;
	logic [NW-1:0] rx_bits_q;
	wire tx_load = tx_valid_i && !tx_busy_o;
	wire tx_tick = tx_cnt_q == '0;
	wire rx_tick = rx_cnt_q == '0;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			tx_busy_o <= 1'b0;
			tx_line_o <= 1'b1;
			tx_sh_q <= '0;
			tx_cnt_q <= '0;
			tx_bits_q <= '0;
		end
		else if (tx_load)
		begin
			tx_busy_o <= 1'b1;
			tx_line_o <= 1'b0;
			tx_sh_q <= {tx_word_i, 1'b1};
			tx_cnt_q <= CW'(BIT_CYCLES - 1);
			tx_bits_q <= NW'(WORD_W + 1);
		end
		else if (tx_busy_o)
		begin
			tx_cnt_q <= tx_tick ? CW'(BIT_CYCLES - 1) : tx_cnt_q - 1'b1;
			if (tx_tick && tx_bits_q != '0)
			begin
				tx_line_o <= tx_sh_q[WORD_W];
				tx_sh_q <= {tx_sh_q[WORD_W-1:0], 1'b1};
				tx_bits_q <= tx_bits_q - 1'b1;
			end
			else if (tx_tick)
			begin
				tx_busy_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The first sample point sits one and a half bits after the start edge.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_act_q <= 1'b0;
			rx_sh_q <= '0;
			rx_cnt_q <= '0;
			rx_bits_q <= '0;
			rx_valid_o <= 1'b0;
			rx_word_o <= '0;
			rx_err_o <= 1'b0;
		end
		else
		begin
			rx_s1_q <= rx_line_i;
			rx_s2_q <= rx_s1_q;
			rx_valid_o <= 1'b0;
			if (!rx_act_q && !rx_s2_q)
			begin
				rx_act_q <= 1'b1;
				rx_cnt_q <= CW'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
				rx_bits_q <= NW'(WORD_W + 1);
			end
			else if (rx_act_q)
			begin
				rx_cnt_q <= rx_tick ? CW'(BIT_CYCLES - 1) : rx_cnt_q - 1'b1;
				if (rx_tick && rx_bits_q != NW'(1))
				begin
					rx_sh_q <= {rx_sh_q[WORD_W-2:0], rx_s2_q};
					rx_bits_q <= rx_bits_q - 1'b1;
				end
				else if (rx_tick)
				begin
					rx_act_q <= 1'b0;
					rx_valid_o <= 1'b1;
					rx_word_o <= rx_sh_q;
					rx_err_o <= !rx_s2_q;
				end
			end
		end
	end
endmodule : word_serdes

/* File: hw/readout_control_assembly.sv */
/*
 * Readout control assembly end of the command link: three sub-units
 * (detector, mechanism, subsystem control), each on its own link.
 * Each sub-unit decodes the command words, hands accepted commands to its
 * user logic and answers individually addressed commands with one word.
 * Assumes the master keeps to one outstanding individual command per link
 * and that hk_data_i comes from logic on sys_clk_i.
 */
//
// Behaviour
// - Commands are 32 bits: address, identifier, parameter.
// - Master starts every transfer; sub-units only answer.
// - Same command on all links; own address only.
// - Broadcast address accepted by all three sub-units.
// - Reply only when addressed individually, indicator zero.
// - Reply carries error report in address position.
// - Reply echoes the command identifier.
// - Reply data: parameter echo or housekeeping value.
// - No reply at all to a broadcast.
// - Master confirms broadcasts with per-unit acknowledge requests; the master unit sends them only when software starts them.
// - Link runs at 312.5 kbit/s, both ways, words.
// - One dedicated two-way link per sub-unit.
// - Bulk data uses a separate one-way frame link.
module readout_control_assembly #(
	parameter int BIT_CYCLES = cmd_link_pkg::BIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	cmd_link_if.subunit link,
	output logic [cmd_link_pkg::SUBUNITS-1:0] cmd_strobe_o,
	output logic [cmd_link_pkg::SUBUNITS-1:0] cmd_broadcast_o,
	output logic [cmd_link_pkg::SUBUNITS-1:0][7:0] cmd_id_o,
	output logic [cmd_link_pkg::SUBUNITS-1:0][15:0] cmd_param_o,
	output logic [cmd_link_pkg::SUBUNITS-1:0][7:0] err_o,
	input wire logic [cmd_link_pkg::SUBUNITS-1:0][15:0] hk_data_i
);
	import cmd_link_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// One independent decoder and link end per sub-unit.
	genvar i;
	generate
		for (i = 0; i < SUBUNITS; i++)
		begin : g_unit
			logic rx_valid;
			logic [WORD_W-1:0] rx_word;
			logic rx_err;
			logic tx_busy;
			logic tx_valid_q;
			logic [WORD_W-1:0] tx_word_q;
			logic strobe_q;
			logic bcast_q;
			logic [7:0] id_q;
			logic [15:0] param_q;
			logic [7:0] err_q;
			logic [7:0] err_set;
			logic [7:0] err_d;
			logic [15:0] rsp_data;

			// Each sub-unit owns its link pair; responses are the only
			// traffic on the response line.
			word_serdes #(
				.BIT_CYCLES(BIT_CYCLES),
				.WORD_W(WORD_W)
			) u_serdes (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.tx_valid_i(tx_valid_q),
				.tx_word_i(tx_word_q),
				.tx_busy_o(tx_busy),
				.tx_line_o(link.rsp_line[i]),
				.rx_line_i(link.cmd_line[i]),
				.rx_valid_o(rx_valid),
				.rx_word_o(rx_word),
				.rx_err_o(rx_err)
			);

			// A word is only acted on when it arrives complete on the
			// line; the sub-unit never transmits on its own initiative.
			wire good_word = rx_valid && !rx_err;
			wire [7:0] addr = addr_of(rx_word);
			wire [7:0] cmd_id = id_of(rx_word);
			wire [15:0] cmd_par = rx_word[15:0];
			wire own_hit = addr == subunit_addr(i);
			wire bcast_hit = addr == ADDR_BCAST;
			wire accept = good_word && (own_hit || bcast_hit);
			wire indiv = own_hit && !rx_word[INDIV_BIT];
			wire rsp_pending = tx_valid_q || tx_busy;
			wire build = accept && indiv && !bcast_hit && !rsp_pending;
			wire overrun = accept && indiv && rsp_pending;

			// Housekeeping reads return the sampled value, all other
			// commands echo their parameter.
			assign rsp_data = (cmd_id == CMD_HK_READ) ? hk_data_i[i] : cmd_par;

			// Errors collect until a response carries them out; an error
			// seen in the same cycle goes into that response word.
			always_comb
			begin
				err_set = 8'h00;
				err_set[ERR_FRAME] = rx_valid && rx_err;
				err_set[ERR_OVERRUN] = overrun;
				err_d = build ? 8'h00 : (err_q | err_set);
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i)
				begin
					tx_valid_q <= 1'b0;
					tx_word_q <= '0;
				end
				else if (build)
				begin
					tx_valid_q <= 1'b1;
					tx_word_q <= {err_q | err_set, cmd_id, rsp_data};
				end
				else if (tx_valid_q && !tx_busy)
				begin
					tx_valid_q <= 1'b0;
				end
			end

			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i)
				begin
					strobe_q <= 1'b0;
					bcast_q <= 1'b0;
					id_q <= 8'h00;
					param_q <= 16'h0000;
					err_q <= 8'h00;
				end
				else
				begin
					strobe_q <= accept;
					err_q <= err_d;
					if (accept)
					begin
						bcast_q <= bcast_hit;
						id_q <= cmd_id;
						param_q <= cmd_par;
					end
				end
			end

			assign cmd_strobe_o[i] = strobe_q;
			assign cmd_broadcast_o[i] = bcast_q;
			assign cmd_id_o[i] = id_q;
			assign cmd_param_o[i] = param_q;
			assign err_o[i] = err_q;
		end
	endgenerate
endmodule : readout_control_assembly

/* File: hw/processing_master_unit.sv */
/*
 * Processing master end of the command link, controlled over APB.
 * Software loads a command word and starts it; the word goes out on all
 * three links at once and the addressed sub-unit's reply is captured.
 * Assumes an APB master on sys_clk_i and the sub-units on cmd_link_if.
 */
module processing_master_unit #(
	parameter int BIT_CYCLES = cmd_link_pkg::BIT_CYCLES,
	parameter int RSP_TIMEOUT_CYCLES = cmd_link_pkg::RSP_TIMEOUT_BITS * cmd_link_pkg::BIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	cmd_link_if.master link
);
	import cmd_link_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND, ST_WAIT} state_t;
	state_t state_q;
	logic [WORD_W-1:0] cmd_q;
	logic [WORD_W-1:0] send_q;
	logic [WORD_W-1:0] rsp_q;
	logic [1:0] src_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [31:0] timer_q;
	logic [31:0] rd_data;
	logic [SUBUNITS-1:0] tx_busy;
	logic [SUBUNITS-1:0] rx_valid;
	logic [SUBUNITS-1:0] rx_err;
	logic [SUBUNITS-1:0][WORD_W-1:0] rx_word;
	logic [SUBUNITS-1:0] tgt_hit;

	////////////////////////////////////////////////////////////////////////
	// The same word is loaded into all three transmitters in one cycle.
	genvar k;
	generate
		for (k = 0; k < SUBUNITS; k++)
		begin : g_link
			word_serdes #(
				.BIT_CYCLES(BIT_CYCLES),
				.WORD_W(WORD_W)
			) u_serdes (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.tx_valid_i(state_q == ST_LOAD),
				.tx_word_i(send_q),
				.tx_busy_o(tx_busy[k]),
				.tx_line_o(link.cmd_line[k]),
				.rx_line_i(link.rsp_line[k]),
				.rx_valid_o(rx_valid[k]),
				.rx_word_o(rx_word[k]),
				.rx_err_o(rx_err[k])
			);
			assign tgt_hit[k] = addr_of(send_q) == subunit_addr(k);
		end
	endgenerate

	// Every individual command waits for its reply, so an address that no sub-unit owns
	// ends in a timeout.
	wire expect_rsp = !send_q[INDIV_BIT];
	wire [1:0] tgt = tgt_hit[2] ? 2'd2 : (tgt_hit[1] ? 2'd1 : 2'd0);
	wire rsp_in = rx_valid[tgt];
	wire timeout = timer_q == 32'(RSP_TIMEOUT_CYCLES - 1);
	wire access = psel_i && penable_i;
	wire done = access && pready_o;
	wire wr = done && pwrite_i;
	wire start = wr && paddr_i == REG_CTRL && pwdata_i[0] && state_q == ST_IDLE;
	wire rd_clr = done && !pwrite_i && paddr_i == REG_IRQ_STAT;
	wire mapped = paddr_i <= REG_IRQ_MASK && paddr_i[1:0] == 2'b00;

	////////////////////////////////////////////////////////////////////////
	// A new start is refused until ST_IDLE: after the reply or timeout, or after sending when no reply is expected.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			send_q <= '0;
			rsp_q <= '0;
			src_q <= 2'd0;
			timer_q <= 32'h0000_0000;
		end
		else
		begin
			timer_q <= (state_q == ST_WAIT) ? timer_q + 32'h0000_0001 : 32'h0000_0000;
			case (state_q)
				ST_IDLE: if (start)
				begin
					send_q <= cmd_q;
					state_q <= ST_LOAD;
				end
				ST_LOAD: state_q <= ST_SEND;
				ST_SEND: if (tx_busy == '0)
				begin
					state_q <= expect_rsp ? ST_WAIT : ST_IDLE;
				end
				ST_WAIT: if (rsp_in || timeout)
				begin
					state_q <= ST_IDLE;
					if (rsp_in)
					begin
						rsp_q <= rx_word[tgt];
						src_q <= tgt;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Event flags: a read clears only the bits it returned, so an event that lands during
	// the read is kept, and a set in the clearing cycle wins.
	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_DONE] = (state_q == ST_SEND && tx_busy == '0 && !expect_rsp)
			|| (state_q == ST_WAIT && rsp_in);
		irq_set[IRQ_TIMEOUT] = state_q == ST_WAIT && !rsp_in && timeout;
		irq_set[IRQ_RSP_ERR] = state_q == ST_WAIT && rsp_in && rx_err[tgt];
		irq_stat_d = (irq_stat_q & ~(rd_clr ? prdata_o[IRQ_W-1:0] : IRQ_W'(0))) | irq_set;
	end

	always_comb
	begin
		rd_data = 32'h0000_0000;
		case (paddr_i)
			REG_CMD: rd_data = cmd_q;
			REG_STATUS: rd_data[0] = state_q != ST_IDLE;
			REG_RSP: rd_data = rsp_q;
			REG_RSP_SRC: rd_data[1:0] = src_q;
			REG_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q;
			REG_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave with one wait state; writes land on the completing edge.
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			cmd_q <= '0;
			irq_mask_q <= '0;
			irq_stat_q <= '0;
			irq_o <= 1'b0;
		end
		else
		begin
			pready_o <= access && !pready_o;
			pslverr_o <= access && !pready_o && !mapped;
			if (access && !pready_o)
			begin
				prdata_o <= rd_data;
			end
			if (wr && paddr_i == REG_CMD)
			begin
				cmd_q <= pwdata_i;
			end
			if (wr && paddr_i == REG_IRQ_MASK)
			begin
				irq_mask_q <= pwdata_i[IRQ_W-1:0];
			end
			irq_stat_q <= irq_stat_d;
			irq_o <= |(irq_stat_d & irq_mask_q);
		end
	end
endmodule : processing_master_unit

/* File: verif/cmd_link_monitor.sv */
/*
 * Checker of the three command links between the master and the sub-units.
 * Assumes it watches the interface lines directly, all on one clock.
 */
module cmd_link_monitor
import cmd_link_pkg::*;
#(
	parameter int BIT_CYCLES = cmd_link_pkg::BIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [SUBUNITS-1:0] cmd_line,
	input wire logic [SUBUNITS-1:0] rsp_line
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FRAME = 34 * BIT_CYCLES;
	localparam int STOP_AT = 33 * BIT_CYCLES + BIT_CYCLES / 2;
	localparam int QUIET = 2 * BIT_CYCLES;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Frame position per line (0..2 command, 3..5 reply) and quiet time after a command.
	logic [5:0] line;
	logic [5:0][15:0] pos_q;
	logic [2:0][15:0] quiet_q;
	assign line = {rsp_line, cmd_line};
	always_ff @(posedge sys_clk_i)
	begin
		for (int k = 0; k < 6; k++)
		begin
			if (rst_i || (pos_q[k] == 16'(FRAME - 1)))
				pos_q[k] <= '0;
			else if ((pos_q[k] != '0) || !line[k])
				pos_q[k] <= pos_q[k] + 16'h0001;
		end
		for (int k = 0; k < 3; k++)
		begin
			if (rst_i)
				quiet_q[k] <= 16'hFFFF;
			else if (pos_q[k] != '0)
				quiet_q[k] <= '0;
			else if (quiet_q[k] != 16'hFFFF)
				quiet_q[k] <= quiet_q[k] + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	cmd_same_a: assert property ((cmd_line == 3'h0) || (cmd_line == 3'h7))
		else $error("command lines differ");
	reset_idle_a: assert property ($fell(rst_i) |-> (cmd_line == 3'h7) && (rsp_line == 3'h7))
		else $error("line not idle after reset");
	for (genvar k = 0; k < 6; k++)
	begin : g_line
		start_bit_a: assert property ((pos_q[k] != '0) && (pos_q[k] < 16'(BIT_CYCLES)) |-> !line[k])
			else $error("start bit too short");
		stop_bit_a: assert property ((pos_q[k] == 16'(STOP_AT)) |-> line[k])
			else $error("stop bit missing after 32 bits");
		bit_edge_a: assert property ((pos_q[k] != '0) && $changed(line[k]) |-> (int'(pos_q[k]) % BIT_CYCLES == 0))
			else $error("line changed off a bit boundary");
	end
	for (genvar i = 0; i < 3; i++)
	begin : g_link
		reply_cause_a: assert property ((pos_q[i+3] == '0) && !rsp_line[i] |-> (quiet_q[i] < 16'(QUIET)))
			else $error("reply without a command");
		reply_idle_a: assert property ((pos_q[i+3] == '0) && !rsp_line[i] |-> cmd_line[i])
			else $error("reply started during a command");
		one_command_a: assert property ((pos_q[i] == '0) && !cmd_line[i] |-> (pos_q[i+3] == '0))
			else $error("command sent while reply in flight");
	end
endmodule : cmd_link_monitor

/* File: verif/tb_top.sv */
/*
 * Bench joining the master and the sub-unit end through the link interface.
 * Assumes a 100 MHz clock and shortened bit and timeout counts.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cmd_link_pkg::*;
	localparam int BITS = 8;
	localparam logic [7:0] ADDRS [3] = '{8'h01, 8'h02, 8'h03};
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] paddr = '0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, perr;
	logic [31:0] pwdata = '0, prdata, rd, last_rsp;
	logic [2:0] strobe, bcast;
	logic [2:0][7:0] cid, err;
	logic [2:0][15:0] cpar;
	logic [2:0][15:0] hk = '0;
	int fails = 0, checks_done = 0, seed = 40440, rsp_low = 0, low_snap;
	int stb_cnt [3] = '{0, 0, 0};
	int snap [3];
	cmd_link_if i_cmd_link_if ();
	processing_master_unit #(.BIT_CYCLES(BITS), .RSP_TIMEOUT_CYCLES(40 * BITS))
		i_processing_master_unit (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
		.link(i_cmd_link_if.master));
	readout_control_assembly #(.BIT_CYCLES(BITS)) i_readout_control_assembly (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(i_cmd_link_if.subunit),
		.cmd_strobe_o(strobe), .cmd_broadcast_o(bcast), .cmd_id_o(cid),
		.cmd_param_o(cpar), .err_o(err), .hk_data_i(hk));
	cmd_link_monitor #(.BIT_CYCLES(BITS)) i_cmd_link_monitor (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .cmd_line(i_cmd_link_if.cmd_line), .rsp_line(i_cmd_link_if.rsp_line));
	initial
	begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i)
	begin
		for (int i = 0; i < 3; i++)
			if (strobe[i] === 1'b1)
				stb_cnt[i] <= stb_cnt[i] + 1;
		if (i_cmd_link_if.rsp_line !== 3'h7)
			rsp_low <= rsp_low + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge sys_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk_i);
		end
		while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rd_chk
	// Starts a command twice (the second start lands while busy) and polls until idle.
	task automatic send(input logic [31:0] w);
		snap = stb_cnt;
		low_snap = rsp_low;
		apb(1'b1, REG_CMD, w);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_CTRL, 32'h1);
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
		end
		while (rd[0] !== 1'b0);
		#1;
	endtask : send
	task automatic strobes(input logic [2:0] exp);
		for (int i = 0; i < 3; i++)
			check(32'(stb_cnt[i] - snap[i]), {31'h0, exp[i]});
	endtask : strobes
	function automatic logic [31:0] exp_rsp(input logic [31:0] w, input logic [15:0] h);
		return {8'h00, w[23:16], (w[23:16] == CMD_HK_READ) ? h : w[15:0]};
	endfunction : exp_rsp
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		int idx;
		logic [31:0] w;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd_chk(REG_STATUS, 32'h0);
		rd_chk(REG_IRQ_STAT, 32'h0);
		rd_chk(REG_IRQ_MASK, 32'h0);
		apb(1'b0, 12'h01C, 32'h0);
		check({31'h0, perr}, 32'h1);
		apb(1'b1, REG_IRQ_MASK, 32'h7);
		rd_chk(REG_IRQ_MASK, 32'h7);
		for (int n = 0; n < 9; n++)
		begin
			idx = n % 3;
			w = $random(seed);
			w[31:24] = ADDRS[idx];
			if (n < 3)
				w[23:16] = CMD_ACK_REQ;
			else if (n < 6)
				w[23:16] = CMD_HK_READ;
			hk[idx] <= 16'($random(seed));
			send(w);
			check({31'h0, irq}, 32'h1);
			rd_chk(REG_IRQ_STAT, 32'h1);
			#1;
			check({31'h0, irq}, 32'h0);
			last_rsp = exp_rsp(w, hk[idx]);
			rd_chk(REG_RSP, last_rsp);
			rd_chk(REG_RSP_SRC, 32'(idx));
			strobes(3'b001 << idx);
			check({cid[idx], cpar[idx]}, w[23:0]);
			check({24'h0, err[idx]}, 32'h0);
		end
		// The acknowledge requests above went out before this broadcast; none is sent after it to confirm it.
		apb(1'b1, REG_IRQ_MASK, 32'h0);
		w = $random(seed);
		w[31:24] = ADDR_BCAST;
		send(w);
		check({31'h0, irq}, 32'h0);
		rd_chk(REG_IRQ_STAT, 32'h1);
		rd_chk(REG_RSP, last_rsp);
		strobes(3'b111);
		check({29'h0, bcast}, 32'h7);
		check({cid[2], cpar[0]}, w[23:0]);
		check(32'(rsp_low - low_snap), 32'h0);
		apb(1'b1, REG_IRQ_MASK, 32'h2);
		w[31:24] = 8'h05;
		send(w);
		check({31'h0, irq}, 32'h1);
		apb(1'b0, REG_IRQ_STAT, 32'h0);
		check({31'h0, rd[IRQ_TIMEOUT]}, 32'h1);
		strobes(3'b000);
		finish_test();
	end
	initial
	begin
		repeat (30000) @(posedge sys_clk_i);
		fails++;
		finish_test();
	end
endmodule : tb_top
